// >>> rtl/msm_pkg.sv
/*
 * Shared constants of the memory soft-error monitor: register offsets,
 * field positions, reset values and the monitor state type.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package msm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_INFO = 8'h08;
	localparam logic [7:0] OFS_IDX  = 8'h0c;
	localparam logic [7:0] OFS_DIV  = 8'h10;

	// monitor_control_reg fields
	localparam int CTRL_ACTIVATE_BIT = 0;
	localparam int CTRL_PCIE_EN_BIT  = 1;

	// monitor_status_reg fields
	localparam int STAT_IDLE_BIT   = 0;
	localparam int STAT_DETECT_BIT = 1;
	localparam int STAT_WATCH_BIT  = 2;
	localparam int STAT_BUSY_BIT   = 3;
	localparam int STAT_IND_BIT    = 4;

	// indication_flags_reg fields
	localparam int INFO_UNC_BIT     = 0;
	localparam int INFO_UNC_OVF_BIT = 1;
	localparam int INFO_COR_BIT     = 2;
	localparam int INFO_COR_OVF_BIT = 3;
	localparam int INFO_ADDR_LSB    = 16;

	// Reset values
	localparam logic [15:0] DIV_RST  = 16'h00ff;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;

	// Interrupt source position at the top-level controller
	localparam int INTR_SRC_BIT = 20;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WATCH,
		ST_DETECT
	} msm_state_t;

endpackage : msm_pkg

// >>> rtl/msm_mem_store.sv
/*
 * Per-memory indication store: four flags and one address.
 * Assumes event strobes are one-cycle pulses on clk_sys_in.
 */
`timescale 1ns/1ps
module msm_mem_store #(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk_sys_in,
	input  wire logic              unc_evt_in,
	input  wire logic              cor_evt_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              watch_in,
	input  wire logic              clear_in,
	output logic      [3:0]        flags_out,
	output logic      [ADDR_W-1:0] addr_out,
	output logic                   pending_out
);

	// Not reset: stored indications survive a device reset, cleared by the monitor
	logic [3:0]        flags_r;
	logic [3:0]        flags_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;

	always_comb begin
		flags_nxt = flags_r;
		addr_nxt  = addr_r;
		// RULE_15 cleared after readout
		if (clear_in) begin
			flags_nxt = 4'h0;
		end
		// RULE_17 uncorrectable with address
		if (unc_evt_in) begin
			// RULE_20 address kept only while watching
			if (watch_in && !flags_nxt[msm_pkg::INFO_UNC_BIT]) begin
				flags_nxt[msm_pkg::INFO_UNC_BIT] = 1'b1;
				addr_nxt                         = addr_in;
			end else begin
				// RULE_18 address lost
				flags_nxt[msm_pkg::INFO_UNC_OVF_BIT] = 1'b1;
			end
		end
		if (cor_evt_in) begin
			// RULE_19 uncorrectable address takes priority
			if (watch_in && !flags_nxt[msm_pkg::INFO_UNC_BIT] && !flags_nxt[msm_pkg::INFO_COR_BIT]
				&& !unc_evt_in) begin
				flags_nxt[msm_pkg::INFO_COR_BIT] = 1'b1;
				addr_nxt                         = addr_in;
			end else begin
				flags_nxt[msm_pkg::INFO_COR_OVF_BIT] = 1'b1;
			end
		end
	end

	// RULE_14 single pending indication
	// RULE_23 kept across device reset
	always_ff @(posedge clk_sys_in) begin
		flags_r <= flags_nxt;
		addr_r  <= addr_nxt;
	end

	assign flags_out   = flags_r;
	assign addr_out    = addr_r;
	assign pending_out = |flags_r;

endmodule : msm_mem_store

// >>> rtl/msm_monitor.sv
/*
 * Memory soft-error monitor: idle, watch and detect states stepped by
 * software through an AXI4-Lite register slave, one store per memory.
 * Assumes memory event strobes are synchronous to clk_sys_in.
 */
// Our own choices: the AXI4-Lite register port and the register addresses.
// Functional notes
// RULE_01: Three states idle, watch, detect; reset enters idle.
// RULE_02: In idle memories still store indications but do not report them.
// RULE_03: In watch the monitor looks at every attached memory.
// RULE_04: A seen indication in watch sets status flag and interrupt.
// RULE_05: In detect, info and index registers show one indication.
// RULE_06: Idle, detect and watch status bits are readable.
// RULE_07: Each activate request from software gives exactly one transition.
// RULE_08: Activate stays set until the next state is reached.
// RULE_09: Busy bit is high throughout a transition.
// RULE_10: First activate clears all memories and goes idle to watch.
// RULE_11: Software programs the speed divider before the first activate.
// RULE_12: Software enables PCIe MAC memory monitoring only with PCIe on.
// RULE_13: Readout goes watch, idle, then detects until watch returns.
// RULE_14: Each memory holds only one pending indication.
// RULE_15: A memory's indication clears once the monitor has read it.
// RULE_16: Indication is four flags plus one address.
// RULE_17: Upset with keepable address sets its flag and stores address.
// RULE_18: Upset without stored address sets the matching overflow flag.
// RULE_19: Uncorrectable information wins over correctable information.
// RULE_20: Addresses are captured only during watch.
// RULE_21: Correctable and uncorrectable read errors are reported as integrity events.
// RULE_22: Software reboots on an unlisted memory index.
// RULE_23: Device reset leaves memory indications unchanged.
// RULE_24: Integrity interrupt sits at source bit 20.
// RULE_25: From detect, step to next pending memory or back to watch.
`timescale 1ns/1ps
module msm_monitor #(
	parameter int              NUM_MEM   = 8,
	parameter int              ADDR_W    = 12,
	parameter logic [31:0]     PCIE_MASK = 32'h0000_0000
) (
	input  wire logic                      clk_sys_in,
	input  wire logic                      sys_rst_in,
	input  wire logic [7:0]                s_axi_awaddr_in,
	input  wire logic                      s_axi_awvalid_in,
	output logic                           s_axi_awready_out,
	input  wire logic [31:0]               s_axi_wdata_in,
	input  wire logic [3:0]                s_axi_wstrb_in,
	input  wire logic                      s_axi_wvalid_in,
	output logic                           s_axi_wready_out,
	output logic [1:0]                     s_axi_bresp_out,
	output logic                           s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	input  wire logic [7:0]                s_axi_araddr_in,
	input  wire logic                      s_axi_arvalid_in,
	output logic                           s_axi_arready_out,
	output logic [31:0]                    s_axi_rdata_out,
	output logic [1:0]                     s_axi_rresp_out,
	output logic                           s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	input  wire logic [NUM_MEM-1:0]        mem_unc_evt_in,
	input  wire logic [NUM_MEM-1:0]        correctable_flag_evt_in,
	input  wire logic [NUM_MEM*ADDR_W-1:0] mem_addr_in,
	output logic                           integrity_interrupt_out,
	output logic [31:0]                    intr_src_out
);

	localparam int IDX_W = (NUM_MEM > 1) ? $clog2(NUM_MEM) : 1;

	if (NUM_MEM < 1 || NUM_MEM > 32 || ADDR_W < 1 || ADDR_W > 16) begin : g_param_check
		$error("msm_monitor: NUM_MEM must be 1..32 and ADDR_W 1..16");
	end

	////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [IDX_W:0] next_pending(input logic [NUM_MEM-1:0] vec,
		input logic [IDX_W:0] start);
		logic [IDX_W:0] res;
		res = '0;
		for (int i = NUM_MEM - 1; i >= 0; i--) begin
			if (vec[i] && (i >= int'(start))) begin
				res = {1'b1, IDX_W'(i)};
			end
		end
		return res;
	endfunction : next_pending

	function automatic logic [2:0] reg_sel(input logic [7:0] addr);
		logic [2:0] sel;
		unique case ({addr[7:2], 2'b00})
			msm_pkg::OFS_CTRL: sel = 3'h0;
			msm_pkg::OFS_STAT: sel = 3'h1;
			msm_pkg::OFS_INFO: sel = 3'h2;
			msm_pkg::OFS_IDX:  sel = 3'h3;
			msm_pkg::OFS_DIV:  sel = 3'h4;
			default:           sel = 3'h7;
		endcase
		return sel;
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////////
	// Memory stores

	logic [NUM_MEM-1:0] pend_w;
	logic [3:0]         flags_w [NUM_MEM];
	logic [ADDR_W-1:0]  maddr_w [NUM_MEM];
	logic [NUM_MEM-1:0] clr_vec_r;
	logic [NUM_MEM-1:0] clr_vec_nxt;
	logic [NUM_MEM-1:0] mem_en_w;
	msm_pkg::msm_state_t state_r;
	msm_pkg::msm_state_t state_nxt;
	logic               pcie_en_r;
	logic               pcie_en_nxt;

	// Bypassed PCIe MAC memories are ignored
	assign mem_en_w = ~PCIE_MASK[NUM_MEM-1:0] | {NUM_MEM{pcie_en_r}};

	for (genvar g = 0; g < NUM_MEM; g++) begin : g_mem
		// RULE_21 read errors per memory
		msm_mem_store #(
			.ADDR_W (ADDR_W)
		) u_store (
			.clk_sys_in  (clk_sys_in),
			.unc_evt_in  (mem_unc_evt_in[g] & mem_en_w[g]),
			.cor_evt_in  (correctable_flag_evt_in[g] & mem_en_w[g]),
			.addr_in     (mem_addr_in[g*ADDR_W +: ADDR_W]),
			.watch_in    (state_r == msm_pkg::ST_WATCH),
			.clear_in    (clr_vec_r[g]),
			.flags_out   (flags_w[g]),
			.addr_out    (maddr_w[g]),
			.pending_out (pend_w[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Monitor state

	logic              activate_r;
	logic              activate_nxt;
	logic              busy_r;
	logic              busy_nxt;
	logic [15:0]       cnt_r;
	logic [15:0]       cnt_nxt;
	logic              first_r;
	logic              first_nxt;
	logic              ind_r;
	logic              ind_nxt;
	logic [IDX_W-1:0]  idx_r;
	logic [IDX_W-1:0]  idx_nxt;
	logic [31:0]       info_r;
	logic [31:0]       info_nxt;
	logic [15:0]       div_r;
	logic [15:0]       div_nxt;
	logic [31:0]       intr_r;
	logic [31:0]       intr_nxt;
	logic [NUM_MEM-1:0] seen_w;

	// RULE_03 every attached memory watched
	assign seen_w = pend_w & mem_en_w;

	// Register-bus side effects, produced by the bus section
	logic              wr_do;
	logic [2:0]        wr_sel;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;

	always_comb begin
		logic [IDX_W:0] hit;
		hit          = '0;
		state_nxt    = state_r;
		activate_nxt = activate_r;
		busy_nxt     = busy_r;
		cnt_nxt      = cnt_r;
		first_nxt    = first_r;
		ind_nxt      = ind_r;
		idx_nxt      = idx_r;
		info_nxt     = info_r;
		div_nxt      = div_r;
		pcie_en_nxt  = pcie_en_r;
		clr_vec_nxt  = '0;

		// RULE_09 busy while transitioning
		if (activate_r && !busy_r) begin
			busy_nxt = 1'b1;
			cnt_nxt  = div_r;
		end else if (busy_r && cnt_r != 16'h0000) begin
			cnt_nxt = cnt_r - 16'h0001;
		end else if (busy_r) begin
			busy_nxt     = 1'b0;
			// RULE_08 cleared on arrival
			activate_nxt = 1'b0;
			unique case (state_r)
				msm_pkg::ST_IDLE: begin
					if (first_r) begin
						// RULE_10 clear all, go to watch
						first_nxt   = 1'b0;
						clr_vec_nxt = '1;
						state_nxt   = msm_pkg::ST_WATCH;
					end else begin
						// RULE_13 readout walk from idle
						hit = next_pending(seen_w, '0);
						if (hit[IDX_W]) begin
							state_nxt = msm_pkg::ST_DETECT;
							idx_nxt   = hit[IDX_W-1:0];
						end else begin
							state_nxt = msm_pkg::ST_WATCH;
						end
					end
				end
				msm_pkg::ST_WATCH: begin
					state_nxt = msm_pkg::ST_IDLE;
				end
				msm_pkg::ST_DETECT: begin
					// RULE_15 read-out memory cleared
					clr_vec_nxt[idx_r] = 1'b1;
					// RULE_25 next pending or back to watch
					hit = next_pending(seen_w & ~(NUM_MEM'(1) << idx_r), {1'b0, idx_r});
					if (hit[IDX_W]) begin
						idx_nxt = hit[IDX_W-1:0];
					end else begin
						state_nxt = msm_pkg::ST_WATCH;
					end
				end
			endcase
		end

		// RULE_05 info and index shown in detect
		if (state_nxt == msm_pkg::ST_DETECT) begin
			// RULE_16 four flags and address
			info_nxt = (32'(maddr_w[idx_nxt]) << msm_pkg::INFO_ADDR_LSB) | 32'(flags_w[idx_nxt]);
		end

		// Status flag clear by writing one
		if (wr_do && wr_sel == 3'h1 && wr_strb[0] && wr_data[msm_pkg::STAT_IND_BIT]) begin
			ind_nxt = 1'b0;
		end
		// RULE_02 idle stores, no report
		// RULE_04 indication seen while watching, set wins
		// Store being cleared no longer counts
		if (state_r == msm_pkg::ST_WATCH && |(seen_w & ~clr_vec_r)) begin
			ind_nxt = 1'b1;
		end

		if (wr_do && wr_sel == 3'h0 && wr_strb[0]) begin
			pcie_en_nxt = wr_data[msm_pkg::CTRL_PCIE_EN_BIT];
			// RULE_07 one request per write
			if (wr_data[msm_pkg::CTRL_ACTIVATE_BIT]) begin
				activate_nxt = 1'b1;
			end
		end
		if (wr_do && wr_sel == 3'h4) begin
			if (wr_strb[0]) begin
				div_nxt[7:0] = wr_data[7:0];
			end
			if (wr_strb[1]) begin
				div_nxt[15:8] = wr_data[15:8];
			end
		end

		// RULE_24 source bit 20
		intr_nxt                        = '0;
		intr_nxt[msm_pkg::INTR_SRC_BIT] = ind_nxt;
	end

	// RULE_01 reset enters idle
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r    <= msm_pkg::ST_IDLE;
			activate_r <= 1'b0;
			busy_r     <= 1'b0;
			cnt_r      <= 16'h0000;
			first_r    <= 1'b1;
			ind_r      <= 1'b0;
			idx_r      <= '0;
			info_r     <= msm_pkg::DATA_RST;
			div_r      <= msm_pkg::DIV_RST;
			pcie_en_r  <= 1'b0;
			clr_vec_r  <= '0;
			intr_r     <= msm_pkg::DATA_RST;
		end else begin
			state_r    <= state_nxt;
			activate_r <= activate_nxt;
			busy_r     <= busy_nxt;
			cnt_r      <= cnt_nxt;
			first_r    <= first_nxt;
			ind_r      <= ind_nxt;
			idx_r      <= idx_nxt;
			info_r     <= info_nxt;
			div_r      <= div_nxt;
			pcie_en_r  <= pcie_en_nxt;
			clr_vec_r  <= clr_vec_nxt;
			intr_r     <= intr_nxt;
		end
	end

	assign integrity_interrupt_out = ind_r;
	assign intr_src_out            = intr_r;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic        aw_have_r;
	logic        aw_have_nxt;
	logic [7:0]  aw_addr_r;
	logic [7:0]  aw_addr_nxt;
	logic        w_have_r;
	logic        w_have_nxt;
	logic [31:0] w_data_r;
	logic [31:0] w_data_nxt;
	logic [3:0]  w_strb_r;
	logic [3:0]  w_strb_nxt;
	logic        bvalid_r;
	logic        bvalid_nxt;
	logic [1:0]  bresp_r;
	logic [1:0]  bresp_nxt;
	logic        rvalid_r;
	logic        rvalid_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0]  rresp_r;
	logic [1:0]  rresp_nxt;
	logic [31:0] stat_w;

	// RULE_06 state and busy bits
	always_comb begin
		stat_w                              = '0;
		stat_w[msm_pkg::STAT_IDLE_BIT]      = (state_r == msm_pkg::ST_IDLE);
		stat_w[msm_pkg::STAT_DETECT_BIT]    = (state_r == msm_pkg::ST_DETECT);
		stat_w[msm_pkg::STAT_WATCH_BIT]     = (state_r == msm_pkg::ST_WATCH);
		stat_w[msm_pkg::STAT_BUSY_BIT]      = busy_r | activate_r;
		stat_w[msm_pkg::STAT_IND_BIT]       = ind_r;
	end

	assign wr_do   = aw_have_r && w_have_r && !bvalid_r;
	assign wr_sel  = reg_sel(aw_addr_r);
	assign wr_data = w_data_r;
	assign wr_strb = w_strb_r;

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_strb_nxt  = w_strb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;

		if (s_axi_awvalid_in && !aw_have_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !w_have_r) begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata_in;
			w_strb_nxt = s_axi_wstrb_in;
		end
		if (wr_do) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = (wr_sel == 3'h7) ? msm_pkg::RESP_SLVERR : msm_pkg::RESP_OKAY;
		end else if (bvalid_r && s_axi_bready_in) begin
			bvalid_nxt = 1'b0;
		end

		if (s_axi_arvalid_in && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = msm_pkg::RESP_OKAY;
			unique case (reg_sel(s_axi_araddr_in))
				3'h0:    rdata_nxt = {30'h0, pcie_en_r, activate_r};
				3'h1:    rdata_nxt = stat_w;
				3'h2:    rdata_nxt = info_r;
				3'h3:    rdata_nxt = 32'(idx_r);
				3'h4:    rdata_nxt = {16'h0000, div_r};
				default: begin
					rdata_nxt = msm_pkg::DATA_RST;
					rresp_nxt = msm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready_in) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r  <= 1'b0;
			w_data_r  <= msm_pkg::DATA_RST;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= msm_pkg::RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= msm_pkg::DATA_RST;
			rresp_r   <= msm_pkg::RESP_OKAY;
		end else begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r  <= w_have_nxt;
			w_data_r  <= w_data_nxt;
			w_strb_r  <= w_strb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// Ready is the inverse of a held item, so it comes from a flop
	assign s_axi_awready_out = ~aw_have_r;
	assign s_axi_wready_out  = ~w_have_r;
	assign s_axi_arready_out = ~rvalid_r;
	assign s_axi_bvalid_out  = bvalid_r;
	assign s_axi_bresp_out   = bresp_r;
	assign s_axi_rvalid_out  = rvalid_r;
	assign s_axi_rdata_out   = rdata_r;
	assign s_axi_rresp_out   = rresp_r;

endmodule : msm_monitor

// >>> test/msm_monitor_sva.sv
/* Checker of the monitor's register-bus handshakes and interrupt outputs.
   Assumes it is bound into every msm_monitor instance. */
`timescale 1ns/1ps
module msm_monitor_chk (
	input wire logic        clk_sys_in,
	input wire logic        sys_rst_in,
	input wire logic [7:0]  s_axi_awaddr_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic        integrity_interrupt_out,
	input wire logic [31:0] intr_src_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	function automatic logic bad(input logic [7:0] a);
		return {a[7:2], 2'b00} > msm_pkg::OFS_DIV;
	endfunction : bad
	////////////////////////////////////////////////////////////////
	sequence s_wr_take;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	property p_wr_resp;
		s_wr_take |-> ##2 (s_axi_bvalid_out && s_axi_bresp_out ==
			(bad($past(s_axi_awaddr_in, 2)) ? msm_pkg::RESP_SLVERR : msm_pkg::RESP_OKAY));
	endproperty
	property p_rd_resp;
		s_rd_take |=> s_axi_rvalid_out && (bad($past(s_axi_araddr_in)) ?
			(s_axi_rresp_out == msm_pkg::RESP_SLVERR && s_axi_rdata_out == 32'h0) :
			s_axi_rresp_out == msm_pkg::RESP_OKAY);
	endproperty
	property p_b_hold;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	property p_r_hold;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	property p_blocked;
		(s_axi_rvalid_out |-> !s_axi_arready_out) and
			(!s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out |=> s_axi_bvalid_out);
	endproperty
	property p_rst_quiet;
		$fell(sys_rst_in) |-> !integrity_interrupt_out && !s_axi_bvalid_out && !s_axi_rvalid_out;
	endproperty
	property p_intr_map;
		intr_src_out == (32'(integrity_interrupt_out) << msm_pkg::INTR_SRC_BIT);
	endproperty
	property p_irq_fall;
		$fell(integrity_interrupt_out) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out);
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");
	a_rd_resp: assert property (p_rd_resp) else $error("read response wrong");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	a_blocked: assert property (p_blocked) else $error("bus handshake order wrong");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
	a_intr_map: assert property (p_intr_map) else $error("interrupt source bit wrong");
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
endmodule : msm_monitor_chk

bind msm_monitor msm_monitor_chk u_chk (
	.clk_sys_in, .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
	.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .integrity_interrupt_out, .intr_src_out
);

// >>> test/msm_mem_model.sv
/* Model of the protected memories: fires one-cycle error pulses with an address.
   Assumes it shares the monitor's clock. */
`timescale 1ns/1ps
module msm_mem_model #(
	parameter int NUM_MEM = 8,
	parameter int ADDR_W  = 12
) (
	input  wire logic                      clk_sys_in,
	output logic      [NUM_MEM-1:0]        unc_out,
	output logic      [NUM_MEM-1:0]        cor_out,
	output logic      [NUM_MEM*ADDR_W-1:0] addr_out
);
	initial begin
		unc_out = '0;
		cor_out = '0;
		addr_out = '0;
	end
	task hit(input int m, input logic u, input logic c, input logic [ADDR_W-1:0] a);
		@(posedge clk_sys_in);
		unc_out[m] <= u;
		cor_out[m] <= c;
		addr_out[m*ADDR_W +: ADDR_W] <= a;
		@(posedge clk_sys_in);
		unc_out <= '0;
		cor_out <= '0;
		// Address no longer qualified
		addr_out <= ~addr_out;
	endtask : hit
endmodule : msm_mem_model

// >>> test/msm_monitor_tb.sv
/* Self-checking bench of the monitor driven through its register bus.
   Assumes the package's register map and field positions. */
`timescale 1ns/1ps
module msm_monitor_tb;
	localparam int         NM  = 8;
	localparam int         AW  = 12;
	localparam logic [2:0] IDL = 3'b001;
	localparam logic [2:0] DET = 3'b010;
	localparam logic [2:0] WAT = 3'b100;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic [7:0]            awa = 8'h00;
	logic [7:0]            ara = 8'h00;
	logic [31:0]           wd  = 32'h0;
	logic                  awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic                  awr, wrd, bv, arr, rv, irq;
	logic [1:0]            br, rr;
	logic [31:0]           rd, isrc;
	logic [NM-1:0]         unc, cor;
	logic [NM*AW-1:0]      maddr;
	logic [31:0]           lfsr    = 32'h27fc8481;
	int                    n_fail  = 0;
	int                    checked = 0;

	msm_monitor #(.NUM_MEM(NM), .ADDR_W(AW)) uut (
		.clk_sys_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .mem_unc_evt_in(unc),
		.correctable_flag_evt_in(cor), .mem_addr_in(maddr), .integrity_interrupt_out(irq), .intr_src_out(isrc)
	);
	msm_mem_model #(.NUM_MEM(NM), .ADDR_W(AW)) u_mem (
		.clk_sys_in(clk), .unc_out(unc), .cor_out(cor), .addr_out(maddr)
	);

	initial begin
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	function automatic logic [31:0] info(input logic [3:0] f, input logic [AW-1:0] ad);
		return (32'(ad) << msm_pkg::INFO_ADDR_LSB) | 32'(f);
	endfunction : info
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!(bv && bry));
		r = br;
		bry <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (!(rv && rry));
		d = rd;
		r = rr;
		rry <= 1'b0;
	endtask : axr
	task automatic step(input logic [2:0] st);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		n = 0;
		axw(msm_pkg::OFS_CTRL, 32'h1, r);
		axr(msm_pkg::OFS_CTRL, d, r);
		chk("activate held", d[0], 1'b1);
		axr(msm_pkg::OFS_STAT, d, r);
		chk("busy", d[msm_pkg::STAT_BUSY_BIT], 1'b1);
		while (d[msm_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 100) begin
			axr(msm_pkg::OFS_STAT, d, r);
			n++;
		end
		chk("state", d[2:0], st);
		axr(msm_pkg::OFS_CTRL, d, r);
		chk("activate cleared", d[0], 1'b0);
	endtask : step
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#(20000 * 8);
		n_fail++;
		$display("ERROR watchdog expected finish seen hang");
		print_verdict();
	end

	initial begin
		logic [31:0]   d;
		logic [1:0]    r;
		logic [31:0]   ex [2];
		int            ix [2];
		int            m;
		int            m2;
		logic [AW-1:0] a;
		logic [AW-1:0] b;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		axr(msm_pkg::OFS_STAT, d, r);
		chk("status reset", d, 32'h1);
		axr(msm_pkg::OFS_DIV, d, r);
		chk("divider reset", d, 32'(msm_pkg::DIV_RST));
		axr(8'h14, d, r);
		chk("unmapped read", {r, d[29:0]}, {msm_pkg::RESP_SLVERR, 30'h0});
		axw(8'h20, 32'hffff_ffff, r);
		chk("unmapped write", r, msm_pkg::RESP_SLVERR);
		axw(msm_pkg::OFS_CTRL, 32'h2, r);
		axr(msm_pkg::OFS_CTRL, d, r);
		chk("pcie enable", d, 32'h2);
		axw(msm_pkg::OFS_DIV, 32'd20, r);
		step(WAT);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			m = (k == 0) ? 0 : (k == 1) ? 7 : int'(lfsr[2:0]);
			m2 = (m + 3) % NM;
			a = lfsr[AW+7:8];
			b = lfsr[AW+19:20];
			u_mem.hit(m, 1'b1, 1'b0, a);
			u_mem.hit(m, 1'b0, 1'b1, b);
			u_mem.hit(m2, 1'b0, 1'b1, b);
			repeat (2) @(posedge clk);
			chk("interrupt", {irq, isrc[20]}, 2'b11);
			step(IDL);
			u_mem.hit(m2, 1'b1, 1'b0, a);
			ix[m > m2] = m;
			ex[m > m2] = info(4'h9, a);
			ix[m < m2] = m2;
			ex[m < m2] = info(4'h6, b);
			for (int j = 0; j < 2; j++) begin
				step(DET);
				axr(msm_pkg::OFS_INFO, d, r);
				chk("info", d, ex[j]);
				axr(msm_pkg::OFS_IDX, d, r);
				chk("index", d, 32'(ix[j]));
				chk("index listed", 32'(d < NM), 32'h1);
			end
			step(WAT);
			axw(msm_pkg::OFS_STAT, 32'h10, r);
			axr(msm_pkg::OFS_STAT, d, r);
			chk("status cleared", d, 32'h4);
			chk("interrupt cleared", {irq, isrc[20]}, 2'b00);
			$display("test round %0d done", k);
		end
		u_mem.hit(5, 1'b1, 1'b0, a);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		axr(msm_pkg::OFS_STAT, d, r);
		chk("status rerun", {irq, d[30:0]}, 32'h1);
		chk("store kept", 32'(uut.g_mem[5].u_store.pending_out), 32'h1);
		axw(msm_pkg::OFS_DIV, 32'd20, r);
		step(WAT);
		step(IDL);
		step(WAT);
		$display("test rerun done");
		print_verdict();
	end
endmodule : msm_monitor_tb
